// >>> lbus_pkg.sv
// Purpose: Shared constants and types for the local bus cycle control block.
// Assumes: One clock, core_clk_i at 20 MHz.
// Notes:   Transfer-count codes follow the two low address bits.
package lbus_pkg;
   localparam int unsigned ADDR_W      = 32;
   localparam int unsigned WORD_LSB    = 2;
   localparam int unsigned CNT_W       = 2;
   localparam int unsigned REQ_W       = 32 + 32 + 2 + 1;
   localparam int unsigned FIFO_DEPTH  = 16;
   localparam int unsigned SYNC_STAGES = 3;
   localparam logic [1:0] CNT_ONE   = 2'h0;
   localparam logic [1:0] CNT_TWO   = 2'h1;
   localparam logic [1:0] CNT_THREE = 2'h2;
   localparam logic [1:0] CNT_FOUR  = 2'h3;
   localparam logic [31:0] BUS_RESET = 32'h00000000;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_DATA,
      ST_HOLD,
      ST_HALT
   } bus_state_t;
endpackage

// >>> lbus_fifo.sv
// Purpose: Request FIFO with valid and ready on both sides.
// Assumes: Same clock on both sides.
// Notes:   Full and empty are exact; a push into a full FIFO is refused.
`timescale 1ns/1ps
`default_nettype none
module lbus_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready_o  = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// >>> lbus_cycle_ctl.sv
// Purpose: Bus-master cycle control for a multiplexed 32-bit address/data local bus.
// Assumes: Requests arrive through a 16-word FIFO; ready inputs come from pins or
//          from the memory controller and are synchronised here.
// Notes:   Drives strobe, latch enable, last-transfer indicator and the bus itself.
//
// Behaviour
// - In the address cycle the bus carries the word address on bits 31..2 and the count code on bits 1..0.
// - The count code is 00 for one, 01 for two, 10 for three and 11 for four transfers.
// - On halt after a write bits 31..2 carry the last data value that was written.
// - On halt after a read bits 31..2 carry the last address that was on the bus.
// - On halt bits 1..0 carry the count code of the final completed transaction.
// - The active-low address strobe is low for the whole address cycle.
// - The latch enable is high in the address cycle and low before any wait or data cycle.
// - While the bus is granted away in hold, the latch enable floats.
// - The last-transfer indicator is asserted in the final data transfer of every access.
// - The last-transfer indicator is removed once the final transfer has completed.
`timescale 1ns/1ps
`default_nettype none
module lbus_cycle_ctl (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic [31:0] req_addr_i,
   input  wire logic [31:0] req_wdata_i,
   input  wire logic [1:0]  req_count_i,
   input  wire logic        req_write_i,
   input  wire logic        req_valid_i,
   output logic             req_ready_o,
   input  wire logic        ready_recover_n_i,
   input  wire logic        memctl_ready_recover_n_i,
   input  wire logic        hold_req_i,
   input  wire logic        halt_req_i,
   input  wire logic [31:0] muxed_addr_data_bus_i,
   output logic      [31:0] muxed_addr_data_bus_o,
   output logic             muxed_addr_data_bus_oe_n_o,
   output logic             address_strobe_n_o,
   output logic             addr_latch_en_o,
   output logic             addr_latch_en_oe_n_o,
   output logic             last_transfer_n_o,
   output logic             hold_ack_o,
   output logic             halted_o,
   output logic      [31:0] rdata_o,
   output logic             rdata_valid_o
);
   typedef struct packed {
      lbus_pkg::bus_state_t state;
      logic [1:0]  rdy_sync;
      logic [1:0]  mrdy_sync;
      logic        rdy_s1;
      logic        mrdy_s1;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [1:0]  count;
      logic [1:0]  left;
      logic        write;
      logic [31:0] bus;
      logic        bus_oe_n;
      logic        ads_n;
      logic        ale;
      logic        ale_oe_n;
      logic        last_transfer_n_n;
      logic        hold_ack;
      logic        halted;
      logic [31:0] rdata;
      logic        rvalid;
   } state_t;

   state_t s;
   state_t next_s;

   logic [lbus_pkg::REQ_W-1:0] fifo_in;
   logic [lbus_pkg::REQ_W-1:0] fifo_out;
   logic                       fifo_valid;
   logic                       fifo_pop;
   logic                       ready_seen;

   assign fifo_in = {req_write_i, req_count_i, req_wdata_i, req_addr_i};

   lbus_fifo #(
      .WIDTH(lbus_pkg::REQ_W),
      .DEPTH(lbus_pkg::FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .in_data_i  (fifo_in),
      .in_valid_i (req_valid_i),
      .in_ready_o (req_ready_o),
      .out_data_o (fifo_out),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop)
   );

   // A ready counts only once the second and third stages agree, so a pin
   // edge near the clock cannot produce a half-seen ready.
   assign ready_seen = (!s.rdy_sync[1] && !s.rdy_s1) || (!s.mrdy_sync[1] && !s.mrdy_s1);
   assign fifo_pop   = (s.state == lbus_pkg::ST_IDLE) && fifo_valid && !hold_req_i
                       && !halt_req_i;

   always_comb begin
      next_s           = s;
      next_s.rdy_sync  = {s.rdy_sync[0], ready_recover_n_i};
      next_s.mrdy_sync = {s.mrdy_sync[0], memctl_ready_recover_n_i};
      next_s.rdy_s1    = s.rdy_sync[1];
      next_s.mrdy_s1   = s.mrdy_sync[1];
      next_s.ads_n     = 1'b1;
      next_s.ale       = 1'b0;
      next_s.rvalid    = 1'b0;
      unique case (s.state)
         lbus_pkg::ST_IDLE: begin
            next_s.last_transfer_n_n = 1'b1;
            if (hold_req_i) begin
               next_s.state    = lbus_pkg::ST_HOLD;
               next_s.hold_ack = 1'b1;
               next_s.bus_oe_n = 1'b1;
               next_s.ale_oe_n = 1'b1;
            end else if (halt_req_i) begin
               // The upper bits show the last data (write) or the last
               // address (read). The two low bits always show the count
               // code of the final access, so an observer watching a
               // halted bus can tell how long that access was, even
               // after a write whose low data bits would say otherwise.
               next_s.state    = lbus_pkg::ST_HALT;
               next_s.halted   = 1'b1;
               next_s.bus_oe_n = 1'b0;
               if (!s.write) begin
                  next_s.bus = {s.addr[lbus_pkg::ADDR_W-1:lbus_pkg::WORD_LSB],
                                s.count};
               end else begin
                  next_s.bus = {s.wdata[lbus_pkg::ADDR_W-1:lbus_pkg::WORD_LSB],
                                s.count};
               end
            end else if (fifo_valid) begin
               next_s.state    = lbus_pkg::ST_ADDR;
               next_s.addr     = fifo_out[31:0];
               next_s.wdata    = fifo_out[63:32];
               next_s.count    = fifo_out[65:64];
               next_s.write    = fifo_out[66];
               next_s.left     = fifo_out[65:64];
               next_s.bus      = {fifo_out[lbus_pkg::ADDR_W-1:lbus_pkg::WORD_LSB],
                                  fifo_out[65:64]};
               next_s.bus_oe_n = 1'b0;
               next_s.ads_n    = 1'b0;
               next_s.ale      = 1'b1;
            end
         end
         lbus_pkg::ST_ADDR: begin
            next_s.state    = lbus_pkg::ST_DATA;
            next_s.bus_oe_n = !s.write;
            if (s.write) begin
               next_s.bus = s.wdata;
            end
            next_s.last_transfer_n_n = (s.left != lbus_pkg::CNT_ONE);
         end
         lbus_pkg::ST_DATA: begin
            if (ready_seen) begin
               next_s.rvalid = !s.write;
               next_s.rdata  = muxed_addr_data_bus_i;
               if (s.left == lbus_pkg::CNT_ONE) begin
                  next_s.state   = lbus_pkg::ST_IDLE;
                  next_s.last_transfer_n_n = 1'b1;
               end else begin
                  next_s.left    = s.left - 2'h1;
                  next_s.last_transfer_n_n = (s.left != lbus_pkg::CNT_TWO);
               end
            end
            // Without a ready the indicator simply keeps its value.
         end
         lbus_pkg::ST_HOLD: begin
            if (!hold_req_i) begin
               next_s.state    = lbus_pkg::ST_IDLE;
               next_s.hold_ack = 1'b0;
               next_s.bus_oe_n = 1'b0;
               next_s.ale_oe_n = 1'b0;
            end
         end
         lbus_pkg::ST_HALT: begin
            if (!halt_req_i) begin
               next_s.state  = lbus_pkg::ST_IDLE;
               next_s.halted = 1'b0;
            end
         end
         default: begin
            next_s.state = lbus_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s           <= '0;
         s.state     <= lbus_pkg::ST_IDLE;
         s.rdy_sync  <= 2'h3;
         s.mrdy_sync <= 2'h3;
         s.rdy_s1    <= 1'b1;
         s.mrdy_s1   <= 1'b1;
         s.bus       <= lbus_pkg::BUS_RESET;
         s.bus_oe_n  <= 1'b1;
         s.ads_n     <= 1'b1;
         s.ale_oe_n  <= 1'b0;
         s.last_transfer_n_n   <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign muxed_addr_data_bus_o      = s.bus;
   assign muxed_addr_data_bus_oe_n_o = s.bus_oe_n;
   assign address_strobe_n_o         = s.ads_n;
   assign addr_latch_en_o            = s.ale;
   assign addr_latch_en_oe_n_o       = s.ale_oe_n;
   assign last_transfer_n_o          = s.last_transfer_n_n;
   assign hold_ack_o                 = s.hold_ack;
   assign halted_o                   = s.halted;
   assign rdata_o                    = s.rdata;
   assign rdata_valid_o              = s.rvalid;
endmodule
`default_nettype wire

// >>> lbus_cycle_ctl_checker.sv
// Purpose: Port assertions for the local bus cycle control block.
// Assumes: One clock, reset active high.
// Notes:   Ready passes a three-flop pipeline before it is seen.
`timescale 1ns/1ps
`default_nettype none
module lbus_cycle_ctl_checker (
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   input wire logic        ready_recover_n_i,
   input wire logic        memctl_ready_recover_n_i,
   input wire logic [31:0] muxed_addr_data_bus_o,
   input wire logic        muxed_addr_data_bus_oe_n_o,
   input wire logic        address_strobe_n_o,
   input wire logic        addr_latch_en_o,
   input wire logic        addr_latch_en_oe_n_o,
   input wire logic        last_transfer_n_o,
   input wire logic        hold_ack_o,
   input wire logic        halted_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   sequence addr_cyc;
      !address_strobe_n_o && addr_latch_en_o;
   endsequence
   sequence no_ready;
      (!last_transfer_n_o && ready_recover_n_i && memctl_ready_recover_n_i) [*4];
   endsequence
   sequence ready_held;
      (!last_transfer_n_o && !ready_recover_n_i) [*3];
   endsequence
   AST_STROBE_ALE: assert property (!address_strobe_n_o |-> addr_cyc)
      else $error("strobe low without latch enable");
   AST_ONE_ADDR: assert property (addr_cyc |=> address_strobe_n_o && !addr_latch_en_o)
      else $error("address cycle longer than one cycle");
   AST_ADDR_DRIVEN: assert property (addr_cyc |-> !muxed_addr_data_bus_oe_n_o && last_transfer_n_o)
      else $error("address cycle not driven or last asserted");
   AST_LAST_FIRST: assert property (addr_cyc |=>
      last_transfer_n_o == ($past(muxed_addr_data_bus_o[1:0]) != 2'h0))
      else $error("last indicator wrong after address cycle");
   AST_LAST_WAIT: assert property (no_ready |=> !last_transfer_n_o)
      else $error("last indicator dropped during wait");
   AST_LAST_END: assert property (ready_held |-> ##[1:4] last_transfer_n_o)
      else $error("last indicator not removed");
   AST_HOLD_FLOAT: assert property (hold_ack_o |-> addr_latch_en_oe_n_o && muxed_addr_data_bus_oe_n_o)
      else $error("latch enable driven in hold");
   AST_HALT_DRIVE: assert property (halted_o |-> !muxed_addr_data_bus_oe_n_o && address_strobe_n_o)
      else $error("bus not driven in halt");
endmodule
bind lbus_cycle_ctl lbus_cycle_ctl_checker chk (.core_clk_i, .rst_i, .ready_recover_n_i,
   .memctl_ready_recover_n_i, .muxed_addr_data_bus_o, .muxed_addr_data_bus_oe_n_o,
   .address_strobe_n_o, .addr_latch_en_o, .addr_latch_en_oe_n_o, .last_transfer_n_o,
   .hold_ack_o, .halted_o);
`default_nettype wire

// >>> lbus_agent_model.sv
// Purpose: Behavioural memory agent on the local bus.
// Assumes: Read data is the inverted address-cycle word.
// Notes:   Ready stays low until the final transfer ends.
`timescale 1ns/1ps
`default_nettype none
module lbus_agent_model (
   input  wire logic        core_clk_i,
   input  wire logic        slow_i,
   input  wire logic        use_mc_i,
   input  wire logic        strobe_n_i,
   input  wire logic        last_n_i,
   input  wire logic [31:0] bus_i,
   output logic             rdy_n_o,
   output logic             mc_rdy_n_o,
   output var logic         busy_o = 1'b0,
   output logic      [31:0] data_o
);
   logic [31:0] word = 32'h0;
   logic [31:0] pat = 32'h0;
   logic [3:0]  wt = 4'h0;
   logic        last_q = 1'b1;
   always @(posedge core_clk_i) begin
      last_q <= last_n_i;
      pat <= ~pat;
      if (!strobe_n_i) begin
         word <= ~bus_i;
         busy_o <= 1'b1;
         wt <= slow_i ? 4'hC : 4'h1;
      end else if (wt != 4'h0) begin
         wt <= wt - 4'h1;
      end else if (last_n_i && !last_q) begin
         busy_o <= 1'b0;
      end
   end
   assign rdy_n_o = !(busy_o && wt == 4'h0 && !use_mc_i);
   assign mc_rdy_n_o = !(busy_o && wt == 4'h0 && use_mc_i);
   // A released bus must not echo the last word, or a stale read would pass.
   assign data_o = busy_o ? word : pat;
endmodule
`default_nettype wire

// >>> testbench.sv
// Purpose: Self-checking bench for the local bus cycle control block.
// Assumes: The agent answers reads with the inverted address word.
// Notes:   Halt is left through a second reset.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk = 0, rst = 1, wr = 0, valid = 0, hold = 0, halt = 0, slow = 0, use_mc = 0;
   logic        refused = 0, rdy_n, mc_rdy_n, busy, ready, oe_n, ale_oe_n, strobe_n, last_n;
   logic        hold_ack, halted, rvalid;
   logic [1:0]  cnt = 2'h0;
   logic [31:0] addr = 0, wdata = 0, rnd = 32'h53, bus_o, mdl_data, rdata;
   logic [31:0] exp_addr[$], exp_rd[$];
   int          fails = 0, n_compared = 0, cyc = 0;
   wire  [31:0] bus_in = oe_n ? mdl_data : bus_o;
   lbus_cycle_ctl DUT (
      .core_clk_i(clk), .rst_i(rst), .req_addr_i(addr), .req_wdata_i(wdata),
      .req_count_i(cnt), .req_write_i(wr), .req_valid_i(valid), .req_ready_o(ready),
      .ready_recover_n_i(rdy_n), .memctl_ready_recover_n_i(mc_rdy_n), .hold_req_i(hold),
      .halt_req_i(halt), .muxed_addr_data_bus_i(bus_in), .muxed_addr_data_bus_o(bus_o),
      .muxed_addr_data_bus_oe_n_o(oe_n), .address_strobe_n_o(strobe_n), .addr_latch_en_o(),
      .addr_latch_en_oe_n_o(ale_oe_n), .last_transfer_n_o(last_n), .hold_ack_o(hold_ack),
      .halted_o(halted), .rdata_o(rdata), .rdata_valid_o(rvalid));
   lbus_agent_model agent (.core_clk_i(clk), .slow_i(slow), .use_mc_i(use_mc),
      .strobe_n_i(strobe_n), .last_n_i(last_n), .bus_i(bus_in), .rdy_n_o(rdy_n),
      .mc_rdy_n_o(mc_rdy_n), .busy_o(busy), .data_o(mdl_data));
   always #25 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Called at a falling edge; leaves valid high so pushes run back to back.
   task push(input logic [1:0] c, input logic w);
      rnd = lfsr(rnd);
      addr = rnd;
      wdata = {rnd[15:0], rnd[31:16]};
      cnt = c;
      wr = w;
      use_mc = rnd[5];
      valid = 1;
      while (!ready) begin
         refused = 1;
         @(negedge clk);
      end
      exp_addr.push_back({rnd[31:2], c});
      if (!w) repeat (int'(c) + 1) exp_rd.push_back(~{rnd[31:2], c});
      @(negedge clk);
   endtask
   task drain;
      valid = 0;
      for (int i = 0; i < 3000 && (exp_addr.size() > 0 || busy || !strobe_n); i++) @(negedge clk);
      @(negedge clk);
   endtask
   task automatic wait_hi(ref logic s);
      for (int i = 0; i < 100 && s !== 1'b1; i++) @(negedge clk);
   endtask
   always @(posedge clk) begin
      #1;
      if (strobe_n === 1'b0) check("address", bus_o, exp_addr.size() ? exp_addr.pop_front() : 32'hXXXXXXXX);
      if (rvalid === 1'b1) check("read data", rdata, exp_rd.size() ? exp_rd.pop_front() : 32'hXXXXXXXX);
   end
   always @(posedge clk) if (++cyc > 20000) begin
      fails++;
      report_and_stop;
   end
   initial begin
      repeat (12) @(negedge clk);
      rst = 0;
      for (int w = 0; w < 2; w++) for (int c = 0; c < 4; c++) push(2'(c), w[0]);
      drain;
      slow = 1;
      repeat (18) push(rnd[1:0], rnd[2]);
      check("refused", refused, 1);
      drain;
      slow = 0;
      hold = 1;
      wait_hi(hold_ack);
      check("latch float", ale_oe_n, 1);
      hold = 0;
      repeat (3) @(negedge clk);
      push(2'h2, 1);
      drain;
      halt = 1;
      wait_hi(halted);
      check("halt data", bus_o[31:2], wdata[31:2]);
      check("halt code", bus_o[1:0], 2'h2);
      rst = 1;
      halt = 0;
      repeat (2) @(negedge clk);
      rst = 0;
      push(2'h1, 0);
      drain;
      halt = 1;
      wait_hi(halted);
      check("halt address", bus_o, {addr[31:2], 2'h1});
      check("beats left", exp_rd.size(), 0);
      report_and_stop;
   end
endmodule
`default_nettype wire
